/* rtl/smc_pkg.sv */
package smc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] SMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMC_STAT_OFS = 8'h04;
  localparam logic [7:0] SMC_CTRL_RST = 8'h00;

  // Field positions in sleep_control
  localparam int SMC_ARM_BIT = 0;
  localparam int SMC_MODE_LSB = 1;
  localparam int SMC_MODE_MSB = 2;

  // Field positions in the status register
  localparam int SMC_STAT_ASLEEP_BIT = 0;
  localparam int SMC_STAT_WAKING_BIT = 1;
  localparam int SMC_STAT_MODE_LSB = 2;
  localparam int SMC_STAT_MODE_MSB = 3;
  localparam int SMC_STAT_LOCK_BIT = 4;

  // ************************************************************
  // Codes and timing
  // ************************************************************
  typedef enum logic [1:0] {
    SMC_IDLE = 2'h0,
    SMC_STANDBY = 2'h1,
    SMC_POWER_DOWN_CODE = 2'h2,
    SMC_RESERVED = 2'h3
  } smc_mode_type;

  typedef enum logic [1:0] {
    SMC_ACTIVE = 2'b00,
    SMC_ASLEEP = 2'b01,
    SMC_WAKING = 2'b10
  } smc_state_type;

  // Wake-up latency in peripheral clock cycles
  localparam logic [2:0] SMC_WAKE_CYCLES = 3'h6;
  // Brown-out active-mode setting that holds execution until ready
  localparam logic [1:0] SMC_BOD_WAIT_CFG = 2'h3;

endpackage

/* rtl/smc_wake_if.sv */
`timescale 1ns/1ns
interface smc_wake_if;
  logic start;
  logic need_osc;
  logic need_bod;
  logic osc_ready;
  logic bod_ready;
  logic done;

  modport ctl (
    output start,
    output need_osc,
    output need_bod,
    output osc_ready,
    output bod_ready,
    input done
  );

  modport tmr (
    input start,
    input need_osc,
    input need_bod,
    input osc_ready,
    input bod_ready,
    output done
  );
endinterface

/* rtl/smc_wake_timer.sv */
`timescale 1ns/1ns
module smc_wake_timer
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  smc_wake_if.tmr wk
);

  typedef struct packed {
    logic busy;
    logic [2:0] cnt;
  } smc_tmr_type;

  smc_tmr_type q;
  smc_tmr_type d;
  logic count_end;

  // ************************************************************
  // Latency counter
  // ************************************************************
  assign count_end = q.busy && (q.cnt == SMC_WAKE_CYCLES - 3'h1);
  // Oscillator and brown-out waits overlap the fixed count, not add to it
  assign wk.done = count_end && (!wk.need_osc || wk.osc_ready)
                 && (!wk.need_bod || wk.bod_ready);

  always_comb begin
    d = q;
    if (wk.start) begin
      d.busy = 1'b1;
      d.cnt = 3'h0;
    end else if (wk.done) begin
      d.busy = 1'b0;
    end else if (q.busy && !count_end) begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_fixed_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    wk.start && !wk.need_osc && !wk.need_bod |-> ##1 (!wk.done)[*5] ##1 wk.done)
    else $error("Wake latency is not six cycles");

  a_bod_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    wk.done && wk.need_bod |-> wk.bod_ready)
    else $error("Wake finished before brown-out ready");

  a_osc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    wk.done && wk.need_osc |-> wk.osc_ready)
    else $error("Wake finished before oscillator ready");

endmodule

/* rtl/smc_sleep_controller.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Debug break wakes from any sleep
// - No enabled interrupt: only reset or debug break resumes
// - Sleep needs arm bit plus sleep instruction
// - Mode codes: idle, standby, power-down, reserved
// - Idle: peripherals run, any interrupt wakes
// - Standby: units run only with run-in-standby
// - Standby wake: pin, two-wire, timer, gated sources
// - Standby ADC sleepwalks, window wakes if enabled
// - Power-down: only watchdog and periodic timer
// - Power-down wakes on pin or two-wire only
// - Wake latency six cycles, or oscillator start if longer
// - Idle keeps main clock, no start-up wait
// - Power-down: low-power oscillators only if used
// - Brown-out setting three holds until ready
// - Any reset exits sleep; interrupt then resumes
// - Register contents kept through every sleep
module smc_sleep_controller
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_instr_i,
  input wire logic irq_enabled_any_i,
  input wire logic debug_break_i,
  input wire logic pin_irq_i,
  input wire logic twi_match_i,
  input wire logic tcb_irq_i,
  input wire logic uart_sof_irq_i,
  input wire logic rtc_irq_i,
  input wire logic pit_irq_i,
  input wire logic adc_window_irq_i,
  input wire logic other_irq_i,
  input wire logic uart_run_stby_i,
  input wire logic rtc_run_stby_i,
  input wire logic adc_run_stby_i,
  input wire logic main_osc_run_stby_i,
  input wire logic rtc_osc_run_stby_i,
  input wire logic lp_osc_used_i,
  input wire logic [1:0] bod_active_cfg_i,
  input wire logic main_osc_ready_i,
  input wire logic bod_ready_i,
  output logic cpu_clk_en_o,
  output logic per_clk_en_o,
  output logic rtc_clk_en_o,
  output logic adc_clk_en_o,
  output logic uart_clk_en_o,
  output logic wdt_pit_clk_en_o,
  output logic main_osc_en_o,
  output logic rtc_osc_en_o,
  output logic ulp_osc_en_o,
  output logic adc_sleepwalk_o,
  output logic asleep_o,
  output logic resume_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    smc_state_type st;
    logic arm;
    smc_mode_type cfg_mode;
    smc_mode_type cur_mode;
    logic no_wake;
    logic ack;
    logic [31:0] rdat;
  } smc_ctl_type;

  smc_ctl_type q;
  smc_ctl_type d;

  smc_wake_if wk ();

  logic bus_req;
  logic wr_ctrl;
  logic wake_src;
  logic sleeping;
  logic idle_m;
  logic stby_m;
  logic pdn_m;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  // ************************************************************
  // Wake-up latency timer
  // ************************************************************
  smc_wake_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wk(wk.tmr)
  );

  // ************************************************************
  // Mode decode
  // ************************************************************
  assign sleeping = (q.st == SMC_ASLEEP);
  assign idle_m = (q.cur_mode == SMC_IDLE);
  assign stby_m = (q.cur_mode == SMC_STANDBY);
  assign pdn_m = (q.cur_mode == SMC_POWER_DOWN_CODE);

  // ************************************************************
  // Wake source selection per mode
  // ************************************************************
  always_comb begin
    wake_src = 1'b0;
    case (q.cur_mode)
      SMC_IDLE: begin
        wake_src = pin_irq_i | twi_match_i | tcb_irq_i | uart_sof_irq_i
                 | rtc_irq_i | pit_irq_i | adc_window_irq_i | other_irq_i;
      end
      SMC_STANDBY: begin
        wake_src = pin_irq_i | twi_match_i | tcb_irq_i | pit_irq_i
                 | (uart_sof_irq_i & uart_run_stby_i)
                 | (rtc_irq_i & rtc_run_stby_i)
                 | (adc_window_irq_i & adc_run_stby_i);
      end
      SMC_POWER_DOWN_CODE: begin
        wake_src = pin_irq_i | twi_match_i;
      end
      default: begin
        wake_src = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Wake timer hookup
  // ************************************************************
  // Standby keeps the main oscillator only when asked, so it may skip start-up
  assign wk.start = sleeping && (debug_break_i || (wake_src && !q.no_wake));
  assign wk.need_osc = !idle_m && !(stby_m && main_osc_run_stby_i);
  assign wk.need_bod = (bod_active_cfg_i == SMC_BOD_WAIT_CFG);
  assign wk.osc_ready = main_osc_ready_i;
  assign wk.bod_ready = bod_ready_i;

  // ************************************************************
  // Register read mux
  // ************************************************************
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SMC_CTRL_OFS);

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[SMC_ARM_BIT] = q.arm;
    ctrl_rd[SMC_MODE_MSB:SMC_MODE_LSB] = q.cfg_mode;
    stat_rd = 8'h00;
    stat_rd[SMC_STAT_ASLEEP_BIT] = sleeping;
    stat_rd[SMC_STAT_WAKING_BIT] = (q.st == SMC_WAKING);
    stat_rd[SMC_STAT_MODE_MSB:SMC_STAT_MODE_LSB] = q.cur_mode;
    stat_rd[SMC_STAT_LOCK_BIT] = q.no_wake;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d = q;
    d.ack = bus_req;
    if (bus_req) begin
      if (wb_adr_i == SMC_CTRL_OFS) begin
        d.rdat = {24'h000000, ctrl_rd};
      end else if (wb_adr_i == SMC_STAT_OFS) begin
        d.rdat = {24'h000000, stat_rd};
      end else begin
        d.rdat = 32'h00000000;
      end
    end
    // Writing only stores; sleep still needs the instruction
    if (wr_ctrl) begin
      d.arm = wb_dat_i[SMC_ARM_BIT];
      d.cfg_mode = smc_mode_type'(wb_dat_i[SMC_MODE_MSB:SMC_MODE_LSB]);
    end
    case (q.st)
      SMC_ACTIVE: begin
        // Mode and arm are taken as they stand when the instruction runs
        if (sleep_instr_i && q.arm && (q.cfg_mode != SMC_RESERVED)) begin
          d.st = SMC_ASLEEP;
          d.cur_mode = q.cfg_mode;
          d.no_wake = !irq_enabled_any_i;
        end
      end
      SMC_ASLEEP: begin
        // A debug break overrides even the locked-asleep case
        if (wk.start) begin
          d.st = SMC_WAKING;
        end
      end
      SMC_WAKING: begin
        if (wk.done) begin
          d.st = SMC_ACTIVE;
          d.no_wake = 1'b0;
        end
      end
      default: begin
        d.st = SMC_ACTIVE;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Only reset or a control write changes the control bits; sleep and wake leave them alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st <= SMC_ACTIVE;
      q.arm <= SMC_CTRL_RST[SMC_ARM_BIT];
      q.cfg_mode <= smc_mode_type'(SMC_CTRL_RST[SMC_MODE_MSB:SMC_MODE_LSB]);
      q.cur_mode <= SMC_IDLE;
      q.no_wake <= 1'b0;
      q.ack <= 1'b0;
      q.rdat <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Clock domain and oscillator gating
  // ************************************************************
  always_comb begin
    cpu_clk_en_o = (q.st == SMC_ACTIVE);
    per_clk_en_o = 1'b1;
    rtc_clk_en_o = 1'b1;
    adc_clk_en_o = 1'b1;
    uart_clk_en_o = 1'b1;
    main_osc_en_o = 1'b1;
    rtc_osc_en_o = 1'b1;
    ulp_osc_en_o = 1'b1;
    adc_sleepwalk_o = 1'b0;
    if (sleeping) begin
      if (stby_m) begin
        per_clk_en_o = 1'b0;
        rtc_clk_en_o = rtc_run_stby_i;
        adc_clk_en_o = adc_run_stby_i;
        uart_clk_en_o = uart_run_stby_i;
        main_osc_en_o = main_osc_run_stby_i;
        rtc_osc_en_o = rtc_osc_run_stby_i;
        adc_sleepwalk_o = adc_run_stby_i;
      end else if (pdn_m) begin
        per_clk_en_o = 1'b0;
        rtc_clk_en_o = 1'b0;
        adc_clk_en_o = 1'b0;
        uart_clk_en_o = 1'b0;
        main_osc_en_o = 1'b0;
        rtc_osc_en_o = lp_osc_used_i;
        ulp_osc_en_o = lp_osc_used_i;
      end
    end
  end

  // Watchdog and periodic timer clock never stops
  assign wdt_pit_clk_en_o = 1'b1;
  assign asleep_o = sleeping;
  // Pulse lets the interrupt controller service the waking interrupt first
  assign resume_o = (q.st == SMC_WAKING) && wk.done;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_entry_needs_arm: assert property (
    (q.st == SMC_ACTIVE) && sleep_instr_i && !q.arm |=> (q.st == SMC_ACTIVE))
    else $error("Slept without arm bit");

  a_write_no_sleep: assert property (
    (q.st == SMC_ACTIVE) && !sleep_instr_i |=> (q.st == SMC_ACTIVE))
    else $error("Slept without sleep instruction");

  a_reserved_ignored: assert property (
    (q.st == SMC_ACTIVE) && sleep_instr_i && (q.cfg_mode == SMC_RESERVED)
    |=> (q.st == SMC_ACTIVE))
    else $error("Reserved mode entered sleep");

  a_entry_mode: assert property (
    (q.st == SMC_ACTIVE) && sleep_instr_i && q.arm && (q.cfg_mode != SMC_RESERVED)
    |=> sleeping && (q.cur_mode == $past(q.cfg_mode)))
    else $error("Sleep mode not sampled at instruction");

  a_debug_wakes: assert property (
    sleeping && debug_break_i |=> (q.st == SMC_WAKING))
    else $error("Debug break did not wake");

  a_locked_asleep: assert property (
    sleeping && q.no_wake && !debug_break_i |=> sleeping)
    else $error("Woke with no interrupt enabled");

  a_idle_clocks: assert property (
    sleeping && idle_m |-> per_clk_en_o && main_osc_en_o && !cpu_clk_en_o)
    else $error("Idle stopped a peripheral clock");

  a_standby_gate: assert property (
    sleeping && stby_m |-> (rtc_clk_en_o == rtc_run_stby_i)
    && (main_osc_en_o == main_osc_run_stby_i) && !per_clk_en_o)
    else $error("Standby gating wrong");

  a_power_down_code_gates: assert property (
    sleeping && pdn_m |-> !per_clk_en_o && !main_osc_en_o && wdt_pit_clk_en_o
    && (ulp_osc_en_o == lp_osc_used_i))
    else $error("Power-down left a clock running");

  a_power_down_code_wake: assert property (
    sleeping && pdn_m && !debug_break_i && !pin_irq_i && !twi_match_i |=> sleeping)
    else $error("Power-down woke on wrong source");

  a_wake_to_active: assert property (
    (q.st == SMC_WAKING) && wk.done |=> (q.st == SMC_ACTIVE) && cpu_clk_en_o)
    else $error("Wake did not return to active");

  a_bus_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single cycle");

  a_idle_wake: assert property (
    sleeping && idle_m && other_irq_i && !q.no_wake |=> (q.st == SMC_WAKING))
    else $error("Idle ignored an interrupt");

  a_stby_wake: assert property (
    sleeping && stby_m && (pin_irq_i || tcb_irq_i) && !q.no_wake |=> (q.st == SMC_WAKING))
    else $error("Standby ignored a wake source");

  a_adc_sleepwalk: assert property (
    sleeping && stby_m |-> (adc_sleepwalk_o == adc_run_stby_i)
    && (adc_clk_en_o == adc_run_stby_i))
    else $error("Standby converter gating wrong");

  a_osc_wait: assert property (
    (q.st == SMC_WAKING) && wk.need_osc && !main_osc_ready_i |=> (q.st == SMC_WAKING))
    else $error("Woke before oscillator ready");

  a_bod_wait: assert property (
    (q.st == SMC_WAKING) && wk.need_bod && !bod_ready_i |=> (q.st == SMC_WAKING))
    else $error("Woke before brown-out ready");

  a_ctrl_kept: assert property (
    sleeping && !wr_ctrl |=> $stable(q.arm) && $stable(q.cfg_mode))
    else $error("Control bits changed in sleep");

  a_resume_pulse: assert property (
    resume_o |=> !resume_o && cpu_clk_en_o)
    else $error("Resume not a single pulse");

endmodule

/* tb/smc_far_model.sv */
`timescale 1ns/1ns
// ************************************
// Clock controller and brown-out stand-in
// ************************************
module smc_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_osc_en_i,
  input wire logic asleep_i,
  input wire logic bod_slow_i,
  output logic main_osc_ready_o,
  output logic bod_ready_o
);
  // Start-up counts are arbitrary; oscillator and slow brown-out longer than the fixed wake count on purpose
  int osc_cnt;
  int bod_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !main_osc_en_i) begin
      osc_cnt <= 0;
    end else if (osc_cnt < 10) begin
      osc_cnt <= osc_cnt + 1;
    end
    if (rst_i || asleep_i) begin
      bod_cnt <= 0;
    end else if (bod_cnt < 12) begin
      bod_cnt <= bod_cnt + 1;
    end
  end
  // A stopped oscillator reports not ready until fully restarted
  assign main_osc_ready_o = (osc_cnt == 10);
  assign bod_ready_o = bod_slow_i ? (bod_cnt == 12) : (bod_cnt >= 2);
endmodule

/* tb/smc_sleep_controller_tb.sv */
`timescale 1ns/1ns
module smc_sleep_controller_tb;
  import smc_pkg::*;
  // ************************************
  // Wiring
  // ************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic sleep_instr = 1'b0;
  logic irq_en = 1'b1;
  logic dbg = 1'b0;
  logic [7:0] src = 8'h00;
  logic [4:0] stby = 5'h00;
  logic [1:0] bod_cfg = 2'h0;
  logic bod_slow = 1'b1;
  logic lp_used = 1'b1;
  wire [31:0] rdat;
  wire ack;
  wire osc_rdy;
  wire bod_rdy;
  wire asleep;
  wire resume;
  wire [9:0] en;
  int n_fail = 0;
  int n_tests = 0;

  smc_sleep_controller dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sleep_instr_i(sleep_instr), .irq_enabled_any_i(irq_en),
    .debug_break_i(dbg), .pin_irq_i(src[0]), .twi_match_i(src[1]), .tcb_irq_i(src[2]),
    .uart_sof_irq_i(src[3]), .rtc_irq_i(src[4]), .pit_irq_i(src[5]),
    .adc_window_irq_i(src[6]), .other_irq_i(src[7]), .uart_run_stby_i(stby[4]),
    .rtc_run_stby_i(stby[3]), .adc_run_stby_i(stby[2]), .main_osc_run_stby_i(stby[1]),
    .rtc_osc_run_stby_i(stby[0]), .lp_osc_used_i(lp_used), .bod_active_cfg_i(bod_cfg),
    .main_osc_ready_i(osc_rdy), .bod_ready_i(bod_rdy), .cpu_clk_en_o(en[7]),
    .per_clk_en_o(en[0]), .rtc_clk_en_o(en[1]), .adc_clk_en_o(en[2]),
    .uart_clk_en_o(en[3]), .wdt_pit_clk_en_o(en[4]), .main_osc_en_o(en[5]),
    .rtc_osc_en_o(en[8]), .ulp_osc_en_o(en[9]), .adc_sleepwalk_o(en[6]),
    .asleep_o(asleep), .resume_o(resume));

  smc_far_model far (.clk_i(clk_i), .rst_i(rst_i), .main_osc_en_i(en[5]),
    .asleep_i(asleep), .bod_slow_i(bod_slow), .main_osc_ready_o(osc_rdy),
    .bod_ready_o(bod_rdy));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ************************************
  // Tasks
  // ************************************
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (ack !== 1'b1 && k < 20);
    check("wb_ack", 1, ack);
    q = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Writes the control byte, then issues one sleep instruction
  task automatic enter(input logic [2:0] v);
    logic [31:0] q;
    wb(1'b1, SMC_CTRL_OFS, {29'h0, v}, 4'h1, q);
    @(posedge clk_i);
    sleep_instr <= 1'b1;
    @(posedge clk_i);
    sleep_instr <= 1'b0;
    #1;
  endtask

  task automatic wake_wait(output int n);
    n = 0;
    while (resume !== 1'b1 && n < 30) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  // Latency code: 6 exact, 0 longer than six, -1 not judged
  task automatic done_chk(input int n, input int exp_n);
    check("resume", 1, resume);
    if (exp_n > 0) check("latency", exp_n, n);
    if (exp_n == 0) check("latency_long", 1, n > 6);
    @(posedge clk_i);
    #1;
    check("resume_len", 0, resume);
    check("cpu_clk_on", 1, en[7]);
  endtask

  function automatic logic [6:0] exp_en(input logic [1:0] m, input logic [4:0] s);
    if (m == 2'h0) return 7'h3f;
    if (m == 2'h1) return {s[2], s[1], 1'b1, s[4], s[2], s[3], 1'b0};
    return 7'h10;
  endfunction

  function automatic logic exp_wake(input logic [1:0] m, input logic [4:0] s, input int i);
    if (m == 2'h0) return 1'b1;
    if (m == 2'h2) return i < 2;
    return i < 3 || i == 5 || (i == 3 && s[4]) || (i == 4 && s[3]) || (i == 6 && s[2]);
  endfunction

  // ************************************
  // Tests
  // ************************************
  initial begin
    #(40 * 30000);
    n_fail++;
    $display("[ERR] watchdog expected end seen hang");
    print_verdict();
  end

  initial begin
    logic [31:0] q;
    logic [1:0] m;
    int n;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, SMC_CTRL_OFS, 32'h0, 4'h1, q);
    check("ctrl_reset", {24'h0, SMC_CTRL_RST}, q);
    wb(1'b0, SMC_STAT_OFS, 32'h0, 4'h1, q);
    check("status_reset", 32'h0, q);
    wb(1'b1, SMC_CTRL_OFS, 32'hffffffff, 4'h0, q);
    wb(1'b1, 8'h08, 32'hffffffff, 4'h1, q);
    wb(1'b0, 8'h08, 32'h0, 4'h1, q);
    check("unmapped", 32'h0, q);
    wb(1'b0, SMC_CTRL_OFS, 32'h0, 4'h1, q);
    check("ctrl_guarded", 32'h0, q);
    wb(1'b1, SMC_CTRL_OFS, 32'hffffffff, 4'h1, q);
    wb(1'b0, SMC_CTRL_OFS, 32'h0, 4'h1, q);
    check("ctrl_fields", 32'h7, q);
    check("no_sleep_on_write", 0, asleep);
    for (int k = 0; k < 2; k++) begin
      enter(k ? 3'h7 : 3'h0);
      check("refused", 0, asleep);
    end
    // Every wake source against every mode, both standby settings
    for (int c = 0; c < 4; c++) begin
      m = (c == 0) ? 2'h0 : (c == 3) ? 2'h2 : 2'h1;
      @(posedge clk_i);
      stby <= (c == 2) ? 5'h1f : 5'h00;
      for (int i = 0; i < 8; i++) begin
        enter({m, 1'b1});
        check("asleep", 1, asleep);
        check("cpu_clk_off", 0, en[7]);
        check("enables", exp_en(m, stby), en[6:0]);
        check("ulp_osc", (m == 2'h2) ? lp_used : 1'b1, en[9]);
        check("rtc_osc", (m == 2'h0) ? 1'b1 : (m == 2'h1) ? stby[0] : lp_used, en[8]);
        @(posedge clk_i);
        src[i] <= 1'b1;
        wake_wait(n);
        check("wake", exp_wake(m, stby, i), resume);
        if (resume === 1'b1) begin
          done_chk(n, (m == 2'h0 || stby[1]) ? 6 : 0);
        end else begin
          check("still_asleep", 1, asleep);
          @(posedge clk_i);
          dbg <= 1'b1;
          @(posedge clk_i);
          dbg <= 1'b0;
          wake_wait(n);
          done_chk(n, -1);
        end
        @(posedge clk_i);
        src <= 8'h00;
        lp_used <= ~lp_used;
      end
      wb(1'b0, SMC_CTRL_OFS, 32'h0, 4'h1, q);
      check("ctrl_kept", {29'h0, m, 1'b1}, q);
    end
    // Brown-out wait only lengthens a wake when the detector is late
    @(posedge clk_i);
    bod_cfg <= SMC_BOD_WAIT_CFG;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      bod_slow <= b[0];
      enter(3'h1);
      @(posedge clk_i);
      src[0] <= 1'b1;
      wake_wait(n);
      done_chk(n, b == 0 ? 6 : 0);
      @(posedge clk_i);
      src[0] <= 1'b0;
    end
    // Sleep with nothing enabled: a pin interrupt does not wake it, a reset does
    @(posedge clk_i);
    irq_en <= 1'b0;
    enter(3'h5);
    @(posedge clk_i);
    src[0] <= 1'b1;
    wake_wait(n);
    check("locked", 0, resume);
    check("locked_asleep", 1, asleep);
    wb(1'b0, SMC_STAT_OFS, 32'h0, 4'h1, q);
    check("status_locked", 32'h19, q);
    @(posedge clk_i);
    rst_i <= 1'b1;
    src[0] <= 1'b0;
    irq_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check("reset_wake", 0, asleep);
    check("reset_cpu_clk", 1, en[7]);
    wb(1'b0, SMC_CTRL_OFS, 32'h0, 4'h1, q);
    check("ctrl_after_reset", 32'h0, q);
    print_verdict();
  end
endmodule
